// file: core/perf_test_core.sv
// Error counters, error injection and per-timeslot test controls
`timescale 1ns/100ps
module perf_test_core
(
  input wire logic MCLK,
  input wire logic RST,
  // Microport
  input wire logic [3:0] PAGE,
  input wire logic [4:0] ADDR,
  input wire logic [7:0] DIN,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] DOUT,
  // Framer mode and receive events
  input wire logic E1_MODE,
  input wire logic HDB3_MODE,
  input wire logic LOSS_OF_FRAME,
  input wire logic FRAME_WORD_ERR,
  input wire logic FAR_END_ERR,
  input wire logic CHECKSUM_ERR,
  input wire logic BIPOLAR_VIOL,
  input wire logic LINE_BIT_VALID,
  input wire logic LINE_BIT,
  input wire logic MULTIFRAME,
  // Timeslot data paths
  input wire logic SLOT_VALID,
  input wire logic [4:0] SLOT_NUM,
  input wire logic [7:0] SERIAL_DATA_INPUT,
  input wire logic [7:0] RX_LINE_DATA,
  output logic [7:0] TX_LINE_DATA,
  output logic [7:0] SERIAL_DATA_OUTPUT,
  output logic SLOT_OUT_VALID,
  output perf_test_pkg::slot_ctrl_type SLOT_CTRL,
  output logic ROBBED_BIT_ENABLE,
  output logic SIG_FROM_HOST,
  output logic ENCODER_BYPASS,
  output perf_test_pkg::inject_type INJECT,
  output perf_test_pkg::event_type EVENTS
);
  //==============================================================
  // State
  typedef struct packed {
    logic [7:0] prbs_error_counter;     // Receive sequence errors
    logic [7:0] prbs_multiframe_counter; // Receive multiframes
    logic [7:0] framing_word_error_counter;
    logic [15:0] far_end_block_error_counter;
    logic [15:0] violation_counter;
    logic [15:0] checksum_error_counter;
    logic [7:0] line_code_q;            // Excess zero select lives here
    logic [7:0] reset_ctrl_q;           // Clear and pause bits
    logic [7:0] access_ctrl_q;          // Sequence select
    logic [5:0] inject_q;               // Error injection bits
    logic [7:0] ovf_latch_q;            // Sticky overflow bits
    logic [4:0] zero_run_q;             // Current run of line zeros
    logic [14:0] gen_q;                 // Sequence generator
    logic [14:0] chk_q;                 // Sequence checker
    logic [7:0] dout_q;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic out_valid_q;
    logic [7:0] slot_ctrl_q;
    logic robbed_q;
    logic sig_host_q;
    logic [8:0] events_q;
    logic [perf_test_pkg::SLOTS*8-1:0] slots_q; // Per-timeslot bytes
  } state_type;

  state_type st_q;  // Registered state
  state_type st_d;  // Next state

  //==============================================================
  // Sequence helpers, taps for x^15 + x^14 + 1
  // Generator: eight steps, first bit lands in bit 7
  function automatic logic [22:0] gen_byte(input logic [14:0] s);
    logic [14:0] t;
    logic [7:0] b;
    logic nb;
    t = s;
    b = 8'h00;
    for (int i = 7; i >= 0; i--)
    begin
      nb = t[14] ^ t[13];
      b[i] = nb;
      t = {t[13:0], nb};
    end
    return {t, b};
  endfunction : gen_byte

  // Checker: self-synchronising, any mismatching bit flags the byte
  function automatic logic [15:0] chk_byte(input logic [14:0] s,
                                           input logic [7:0] d);
    logic [14:0] t;
    logic e;
    t = s;
    e = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      if (d[i] != (t[14] ^ t[13]))
      begin
        e = 1'b1;
      end
      t = {t[13:0], d[i]};
    end
    return {t, e};
  endfunction : chk_byte

  //==============================================================
  // Next-state logic
  always_comb
  begin
    logic clear;          // Counter clear held high
    logic wr_ctl;         // Write on control page
    logic wr_cnt;         // Write on counter page
    logic viol_inc;
    logic excess;
    logic prbs_err;
    logic [4:0] limit;
    logic [22:0] g;
    logic [15:0] c;
    perf_test_pkg::slot_ctrl_type sc;
    logic [7:0] txb;
    clear = 1'b0;
    wr_ctl = 1'b0;
    wr_cnt = 1'b0;
    viol_inc = 1'b0;
    excess = 1'b0;
    prbs_err = 1'b0;
    limit = 5'h00;
    g = '0;
    c = '0;
    sc = '0;
    txb = 8'h00;
    st_d = st_q;
    st_d.events_q = '0;       // Pulses last one clock  R25
    st_d.out_valid_q = 1'b0;
    clear = st_q.reset_ctrl_q[perf_test_pkg::BIT_CLEAR];
    wr_ctl = WR && (PAGE == perf_test_pkg::PAGE_CTRL);
    wr_cnt = WR && (PAGE == perf_test_pkg::PAGE_COUNT);

    // Control writes
    if (wr_ctl)
    begin
      unique case (ADDR)
        perf_test_pkg::ADR_LINE_CODE: st_d.line_code_q = DIN;
        perf_test_pkg::ADR_INJECT: st_d.inject_q = DIN[5:0]; // R12
        perf_test_pkg::ADR_RESET_CTRL: st_d.reset_ctrl_q = DIN;
        perf_test_pkg::ADR_ACCESS_CTRL: st_d.access_ctrl_q = DIN;
        default: ;
      endcase
    end
    // Slot control writes, page A holds 0..15, page B holds 16..31
    if (WR && (PAGE == perf_test_pkg::PAGE_SLOT_LO ||
               PAGE == perf_test_pkg::PAGE_SLOT_HI) && !ADDR[4])
    begin
      st_d.slots_q[{PAGE == perf_test_pkg::PAGE_SLOT_HI,
                    ADDR[3:0]}*8 +: 8] = DIN; // R14
    end

    // Excess zero tracking on the received line
    limit = HDB3_MODE ? perf_test_pkg::ZERO_LIMIT_HDB3
                      : perf_test_pkg::ZERO_LIMIT_PLAIN;
    if (LINE_BIT_VALID)
    begin
      if (LINE_BIT)
      begin
        st_d.zero_run_q = 5'h00;
      end
      else if (st_q.zero_run_q <= limit)
      begin
        // Saturate one past the limit so a long run counts once
        st_d.zero_run_q = st_q.zero_run_q + 5'h01;
        excess = (st_q.zero_run_q == limit); // R5
      end
    end
    viol_inc = (BIPOLAR_VIOL ||
      (excess && st_q.line_code_q[perf_test_pkg::BIT_EXZ])) && // R5
      !(st_q.reset_ctrl_q[perf_test_pkg::BIT_PAUSE] &&
        LOSS_OF_FRAME); // R8

    // Timeslot data paths
    if (SLOT_VALID)
    begin
      sc = st_q.slots_q[SLOT_NUM*8 +: 8];
      if (!E1_MODE && SLOT_NUM >= 5'd24)
      begin
        sc = '0;  // Only 24 slots exist in T1
      end
      g = gen_byte(st_q.gen_q);
      c = chk_byte(st_q.chk_q, RX_LINE_DATA);
      if (sc.remote_slot_loop)
      begin
        txb = RX_LINE_DATA; // R19
      end
      else if (sc.transmit_test_select &&
               !st_q.access_ctrl_q[perf_test_pkg::BIT_SEQ])
      begin
        txb = g[7:0]; // R21
        st_d.gen_q = g[22:8];
      end
      else
      begin
        txb = SERIAL_DATA_INPUT;
      end
      if (!E1_MODE && sc.idle_insert)
      begin
        txb = ~txb;  // T1 channel inversion
      end
      // Forced loss of signal wins over the encoder
      st_d.tx_q = INJECT.inject_signal_loss ? 8'h00 : txb; // R13
      st_d.rx_q = sc.local_slot_loop ? SERIAL_DATA_INPUT // R18
                                     : RX_LINE_DATA;
      if (sc.receive_test_select &&
          !st_q.access_ctrl_q[perf_test_pkg::BIT_SEQ])
      begin
        st_d.chk_q = c[15:1]; // R22
        prbs_err = c[0];
      end
      st_d.slot_ctrl_q = sc; // R15
      st_d.robbed_q = !E1_MODE && !sc.clear_channel; // R16
      st_d.sig_host_q = sc.host_signalling_select; // R17
      st_d.out_valid_q = 1'b1;
    end

    // Counters: host preset, else events, clear over all
    if (wr_cnt)
    begin
      unique case (ADDR)
        perf_test_pkg::ADR_PRBS_ERR:
        begin
          st_d.prbs_error_counter = DIN;
          st_d.prbs_multiframe_counter = 8'h00; // R1
        end
        perf_test_pkg::ADR_PRBS_MF: st_d.prbs_multiframe_counter = DIN;
        perf_test_pkg::ADR_FRAME_ERR:
          st_d.framing_word_error_counter = DIN;
        perf_test_pkg::ADR_FAR_A:
          st_d.far_end_block_error_counter[7:0] = DIN;
        perf_test_pkg::ADR_FAR_B:
          st_d.far_end_block_error_counter[15:8] = DIN;
        perf_test_pkg::ADR_VIOL_LO:
          st_d.violation_counter[7:0] = DIN; // R7
        perf_test_pkg::ADR_VIOL_HI:
          st_d.violation_counter[15:8] = DIN;
        perf_test_pkg::ADR_CHK_A:
          st_d.checksum_error_counter[7:0] = DIN;
        perf_test_pkg::ADR_CHK_B:
          st_d.checksum_error_counter[15:8] = DIN;
        default: ;
      endcase
    end
    else
    begin
      if (MULTIFRAME)
      begin
        st_d.prbs_multiframe_counter =
          st_q.prbs_multiframe_counter + 8'h01; // R1
      end
      if (FRAME_WORD_ERR)
      begin
        st_d.framing_word_error_counter =
          st_q.framing_word_error_counter + 8'h01; // R2
        st_d.events_q[8] = 1'b1; // R3
        st_d.events_q[7] = (st_q.framing_word_error_counter == 8'hFF);
      end
      if (FAR_END_ERR)
      begin
        st_d.far_end_block_error_counter =
          st_q.far_end_block_error_counter + 16'h0001; // R4
        st_d.events_q[6] = 1'b1;
        st_d.events_q[5] =
          (st_q.far_end_block_error_counter == 16'hFFFF);
      end
      if (viol_inc)
      begin
        st_d.violation_counter = st_q.violation_counter + 16'h0001; // R6
        st_d.events_q[4] = 1'b1; // R9
        st_d.events_q[3] = (st_q.violation_counter == 16'hFFFF);
      end
      if (CHECKSUM_ERR)
      begin
        st_d.checksum_error_counter =
          st_q.checksum_error_counter + 16'h0001; // R10
        st_d.events_q[2] = 1'b1;
        st_d.events_q[1] = (st_q.checksum_error_counter == 16'hFFFF);
      end
      if (prbs_err)
      begin
        st_d.prbs_error_counter = st_q.prbs_error_counter + 8'h01; // R11
        st_d.events_q[0] = (st_q.prbs_error_counter == 8'hFF);
      end
    end
    if (clear)
    begin
      // Hold every counter at zero while the bit stays high
      st_d.prbs_error_counter = 8'h00; // R23
      st_d.prbs_multiframe_counter = 8'h00;
      st_d.framing_word_error_counter = 8'h00;
      st_d.far_end_block_error_counter = 16'h0000;
      st_d.violation_counter = 16'h0000;
      st_d.checksum_error_counter = 16'h0000;
      st_d.events_q = '0;
    end

    // Reads; reading the overflow latch empties it
    if (RD)
    begin
      st_d.dout_q = perf_test_pkg::RESET_BYTE;
      if (PAGE == perf_test_pkg::PAGE_COUNT)
      begin
        unique case (ADDR)
          perf_test_pkg::ADR_PRBS_ERR: st_d.dout_q = st_q.prbs_error_counter;
          perf_test_pkg::ADR_PRBS_MF:
            st_d.dout_q = st_q.prbs_multiframe_counter;
          perf_test_pkg::ADR_FRAME_ERR:
            st_d.dout_q = st_q.framing_word_error_counter;
          perf_test_pkg::ADR_FAR_A:
            st_d.dout_q = st_q.far_end_block_error_counter[7:0];
          perf_test_pkg::ADR_FAR_B:
            st_d.dout_q = st_q.far_end_block_error_counter[15:8];
          perf_test_pkg::ADR_VIOL_LO:
            st_d.dout_q = st_q.violation_counter[7:0];
          perf_test_pkg::ADR_VIOL_HI:
            st_d.dout_q = st_q.violation_counter[15:8];
          perf_test_pkg::ADR_CHK_A:
            st_d.dout_q = st_q.checksum_error_counter[7:0];
          perf_test_pkg::ADR_CHK_B:
            st_d.dout_q = st_q.checksum_error_counter[15:8];
          perf_test_pkg::ADR_OVF_LATCH:
          begin
            st_d.dout_q = st_q.ovf_latch_q;
            st_d.ovf_latch_q = 8'h00; // R24
          end
          default: ;
        endcase
      end
      else if (PAGE == perf_test_pkg::PAGE_CTRL)
      begin
        unique case (ADDR)
          perf_test_pkg::ADR_LINE_CODE: st_d.dout_q = st_q.line_code_q;
          perf_test_pkg::ADR_INJECT: st_d.dout_q = {2'b00, st_q.inject_q};
          perf_test_pkg::ADR_RESET_CTRL: st_d.dout_q = st_q.reset_ctrl_q;
          perf_test_pkg::ADR_ACCESS_CTRL: st_d.dout_q = st_q.access_ctrl_q;
          default: ;
        endcase
      end
      else if ((PAGE == perf_test_pkg::PAGE_SLOT_LO ||
                PAGE == perf_test_pkg::PAGE_SLOT_HI) && !ADDR[4])
      begin
        st_d.dout_q = st_q.slots_q[{PAGE == perf_test_pkg::PAGE_SLOT_HI,
                                    ADDR[3:0]}*8 +: 8];
      end
    end
    // New overflows set after the read clear, so none is lost
    st_d.ovf_latch_q[perf_test_pkg::OVF_FRAME] |= st_d.events_q[7]; // R24
    st_d.ovf_latch_q[perf_test_pkg::OVF_FAR] |= st_d.events_q[5];
    st_d.ovf_latch_q[perf_test_pkg::OVF_VIOL] |= st_d.events_q[3];
    st_d.ovf_latch_q[perf_test_pkg::OVF_CHK] |= st_d.events_q[1];
    st_d.ovf_latch_q[perf_test_pkg::OVF_PRBS] |= st_d.events_q[0];
  end

  //==============================================================
  // State register
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      st_q <= '0;
      st_q.gen_q <= perf_test_pkg::LFSR_SEED;
      st_q.chk_q <= perf_test_pkg::LFSR_SEED;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  //==============================================================
  // Outputs, all straight from flops
  assign DOUT = st_q.dout_q;
  assign TX_LINE_DATA = st_q.tx_q;
  assign SERIAL_DATA_OUTPUT = st_q.rx_q;
  assign SLOT_OUT_VALID = st_q.out_valid_q;
  assign SLOT_CTRL = st_q.slot_ctrl_q;
  assign ROBBED_BIT_ENABLE = st_q.robbed_q;
  assign SIG_FROM_HOST = st_q.sig_host_q;
  assign ENCODER_BYPASS = st_q.inject_q[4]; // R13
  assign INJECT = st_q.inject_q;
  assign EVENTS = st_q.events_q;

  //==============================================================
  // Checks
  frame_count_a: assert property (@(posedge MCLK) disable iff (RST) // R2
    FRAME_WORD_ERR && !WR && !st_q.reset_ctrl_q[4] |=>
      st_q.framing_word_error_counter ==
      $past(st_q.framing_word_error_counter) + 8'h01)
    else $error("framing counter missed an error");
  frame_wrap_a: assert property (@(posedge MCLK) disable iff (RST) // R3
    EVENTS.framing_error_overflow_irq |->
      st_q.framing_word_error_counter == 8'h00 &&
      EVENTS.framing_error_event_irq)
    else $error("framing overflow without wrap");
  event_pulse_a: assert property (@(posedge MCLK) disable iff (RST) // R9
    EVENTS.violation_event_irq |-> st_q.violation_counter ==
      $past(st_q.violation_counter) + 16'h0001)
    else $error("violation event without cause");
  viol_pause_a: assert property (@(posedge MCLK) disable iff (RST) // R8
    st_q.reset_ctrl_q[2] && LOSS_OF_FRAME && !WR && !st_q.reset_ctrl_q[4] |=>
      $stable(st_q.violation_counter))
    else $error("violation counter ran while paused");
  clear_hold_a: assert property (@(posedge MCLK) disable iff (RST) // R23
    st_q.reset_ctrl_q[4] |=> st_q.checksum_error_counter == 16'h0000 &&
      st_q.violation_counter == 16'h0000)
    else $error("counters not held at zero");
  mf_clear_a: assert property (@(posedge MCLK) disable iff (RST) // R1
    WR && PAGE == 4'h4 && ADDR == 5'h10 |=>
      st_q.prbs_multiframe_counter == 8'h00)
    else $error("multiframe counter not cleared");
  ovf_sticky_a: assert property (@(posedge MCLK) disable iff (RST) // R24
    EVENTS.checksum_overflow_irq && !(RD && PAGE == 4'h4 &&
      ADDR == 5'h1F) ##1 !(RD && PAGE == 4'h4 &&
      ADDR == 5'h1F) [*2] |=> st_q.ovf_latch_q[3])
    else $error("overflow latch bit lost");
  loss_wins_a: assert property (@(posedge MCLK) disable iff (RST) // R13
    SLOT_VALID && INJECT.inject_signal_loss |=> TX_LINE_DATA == 8'h00)
    else $error("loss injection did not force zeros");
  remote_loop_a: assert property (@(posedge MCLK) disable iff (RST) // R19
    SLOT_VALID && st_q.slots_q[SLOT_NUM*8+5] && E1_MODE &&
      !INJECT.inject_signal_loss |=> TX_LINE_DATA == $past(RX_LINE_DATA))
    else $error("remote loop data wrong");
endmodule : perf_test_core

// file: core/perf_test_pkg.sv
// Constants and types shared by the error counter and slot test logic
//==============================================================
// Summary of operation
// R1: Multiframe counter counts, loads, clears on error write
// R2: Count each errored frame alignment word
// R3: Framing event on LSB toggle, overflow on wrap
// R4: Sixteen bit far end counter with events
// R5: Excess zero select adds long zero runs
// R6: Sixteen bit violation counter, one per violation
// R7: Host writes low violation byte first
// R8: Pause violation counting while out of frame
// R9: Violation event on LSB toggle, overflow on wrap
// R10: Sixteen bit checksum counter with events
// R11: PRBS error counter with overflow event
// R12: Six error injection bits at one address
// R13: Signal loss injection overrides line encoder
// R14: One control byte per timeslot
// R15: Control byte field order, bit 7 down
// R16: Clear channel stops bit robbing, T1 only
// R17: Host signalling select picks signalling source
// R18: Local loop sends input data to output
// R19: Remote loop returns line data to line
// R20: Host never sets both loops together
// R21: Transmit test slots carry generated sequence
// R22: Receive test slots feed sequence checker
// R23: Counter clear zeroes and holds counters
// R24: Overflow latch bits stick until read
// R25: Events and overflows are one-clock pulses
package perf_test_pkg;
  //==============================================================
  // Register pages and addresses
  localparam logic [3:0] PAGE_CTRL = 4'h1;
  localparam logic [3:0] PAGE_COUNT = 4'h4;
  localparam logic [3:0] PAGE_SLOT_LO = 4'hA;
  localparam logic [3:0] PAGE_SLOT_HI = 4'hB;
  localparam logic [4:0] ADR_PRBS_ERR = 5'h10;
  localparam logic [4:0] ADR_PRBS_MF = 5'h11;
  localparam logic [4:0] ADR_FRAME_ERR = 5'h13;
  localparam logic [4:0] ADR_FAR_A = 5'h14;
  localparam logic [4:0] ADR_FAR_B = 5'h15;
  localparam logic [4:0] ADR_VIOL_LO = 5'h16;
  localparam logic [4:0] ADR_VIOL_HI = 5'h17;
  localparam logic [4:0] ADR_CHK_A = 5'h18;
  localparam logic [4:0] ADR_CHK_B = 5'h19;
  localparam logic [4:0] ADR_OVF_LATCH = 5'h1F;
  localparam logic [4:0] ADR_LINE_CODE = 5'h12;
  localparam logic [4:0] ADR_INJECT = 5'h19;
  localparam logic [4:0] ADR_RESET_CTRL = 5'h1A;
  localparam logic [4:0] ADR_ACCESS_CTRL = 5'h1B;
  //==============================================================
  // Field positions
  localparam int BIT_EXZ = 5;
  localparam int BIT_CLEAR = 4;
  localparam int BIT_PAUSE = 2;
  localparam int BIT_SEQ = 0;
  localparam int OVF_FRAME = 0;
  localparam int OVF_FAR = 1;
  localparam int OVF_VIOL = 2;
  localparam int OVF_CHK = 3;
  localparam int OVF_PRBS = 4;
  //==============================================================
  // Sizes, limits and reset values
  localparam int SLOTS = 32;
  localparam int LFSR_W = 15;
  localparam logic [4:0] ZERO_LIMIT_HDB3 = 5'h03;
  localparam logic [4:0] ZERO_LIMIT_PLAIN = 5'h0F;
  localparam logic [14:0] LFSR_SEED = 15'h7FFF;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  //==============================================================
  // Carriers
  typedef struct packed {
    logic message_source_select;
    logic idle_insert;
    logic remote_slot_loop;
    logic local_slot_loop;
    logic transmit_test_select;
    logic receive_test_select;
    logic host_signalling_select;
    logic clear_channel;
  } slot_ctrl_type;
  typedef struct packed {
    logic inject_payload_error;
    logic inject_signal_loss;
    logic inject_nonframing_word_error;
    logic inject_framing_word_error;
    logic inject_checksum_error;
    logic inject_bipolar_violation;
  } inject_type;
  typedef struct packed {
    logic framing_error_event_irq;
    logic framing_error_overflow_irq;
    logic far_end_event_irq;
    logic far_end_overflow_irq;
    logic violation_event_irq;
    logic violation_overflow_irq;
    logic checksum_event_irq;
    logic checksum_overflow_irq;
    logic prbs_overflow_irq;
  } event_type;
endpackage : perf_test_pkg

// file: test/host_model.sv
// Host processor model on the register port
`timescale 1ns/100ps
module host_model
(
  input wire logic MCLK,
  output logic [3:0] PAGE,
  output logic [4:0] ADDR,
  output logic [7:0] DIN,
  output logic WR,
  output logic RD,
  input wire logic [7:0] DOUT
);
  //==============================================================
  // Idle bus levels at time zero
  initial
  begin
    PAGE = 4'h0;
    ADDR = 5'h00;
    DIN = 8'h00;
    WR = 1'b0;
    RD = 1'b0;
  end
  //==============================================================
  // Bus cycles
  // One write; data inverted once released so stale bytes never match
  task automatic wr(input logic [3:0] p, input logic [4:0] a,
    input logic [7:0] d);
    @(posedge MCLK);
    PAGE <= p;
    ADDR <= a;
    DIN <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
    DIN <= ~d;
  endtask : wr
  // Wide counter preset, low byte always goes first
  task automatic wr16(input logic [4:0] a, input logic [15:0] d);
    wr(4'h4, a, d[7:0]);
    wr(4'h4, a + 5'h01, d[15:8]);
  endtask : wr16
  // One read; data is taken the cycle after the strobe
  task automatic rd(input logic [3:0] p, input logic [4:0] a,
    output logic [7:0] d);
    @(posedge MCLK);
    PAGE <= p;
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    @(posedge MCLK);
    d = DOUT;
  endtask : rd
endmodule : host_model

// file: test/tb_top.sv
// Self-checking bench for the error counter and slot test core
`timescale 1ns/100ps
module tb_top;
  //==============================================================
  // Design inputs, each valued at time zero
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic E1_MODE = 1'b1;
  logic HDB3_MODE = 1'b0;
  logic LOSS_OF_FRAME = 1'b0;
  logic [4:0] ev = 5'h00; // Frame, far end, violation, checksum, multiframe
  logic LINE_BIT_VALID = 1'b0;
  logic LINE_BIT = 1'b1;
  logic SLOT_VALID = 1'b0;
  logic [4:0] SLOT_NUM = 5'h00;
  logic [7:0] SERIAL_DATA_INPUT = 8'h00;
  logic [7:0] RX_LINE_DATA = 8'h00;
  logic [3:0] PAGE;
  logic [4:0] ADDR;
  logic [7:0] DIN;
  logic WR;
  logic RD;
  logic [7:0] DOUT;
  logic [7:0] TX_LINE_DATA;
  logic [7:0] SERIAL_DATA_OUTPUT;
  logic SLOT_OUT_VALID;
  logic ROBBED_BIT_ENABLE;
  logic SIG_FROM_HOST;
  logic ENCODER_BYPASS;
  perf_test_pkg::slot_ctrl_type SLOT_CTRL;
  perf_test_pkg::inject_type INJECT;
  perf_test_pkg::event_type EVENTS;
  int mismatches = 0;
  int checked = 0;
  logic [15:0] lfsr = 16'h0031; // Fixed seed keeps runs repeatable
  logic [7:0] ctl [32]; // Control byte written to each slot
  initial forever #2 MCLK = ~MCLK;
  host_model host (.MCLK, .PAGE, .ADDR, .DIN, .WR, .RD, .DOUT);
  perf_test_core dut
  (
    .MCLK, .RST, .PAGE, .ADDR, .DIN, .WR, .RD, .DOUT, .E1_MODE,
    .HDB3_MODE, .LOSS_OF_FRAME, .FRAME_WORD_ERR(ev[0]),
    .FAR_END_ERR(ev[1]), .BIPOLAR_VIOL(ev[2]), .CHECKSUM_ERR(ev[3]),
    .MULTIFRAME(ev[4]), .LINE_BIT_VALID, .LINE_BIT, .SLOT_VALID,
    .SLOT_NUM, .SERIAL_DATA_INPUT, .RX_LINE_DATA, .TX_LINE_DATA,
    .SERIAL_DATA_OUTPUT, .SLOT_OUT_VALID, .SLOT_CTRL,
    .ROBBED_BIT_ENABLE, .SIG_FROM_HOST, .ENCODER_BYPASS, .INJECT, .EVENTS
  );
  //==============================================================
  // Helpers
  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : step
  // Expected line byte and serial output byte of one slot
  function automatic logic [15:0] path_exp(input logic [7:0] c,
    input logic [7:0] d, input logic [7:0] r);
    return {c[5] ? r : d, c[4] ? d : r};
  endfunction : path_exp
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp8
  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask : cmp1
  // One event pulse; events seen one and two cycles later
  task automatic pulse(input int i, output logic [8:0] hit,
    output logic [8:0] aft);
    @(posedge MCLK);
    ev[i] <= 1'b1;
    @(posedge MCLK);
    ev[i] <= 1'b0;
    #1;
    hit = EVENTS;
    @(posedge MCLK);
    #1;
    aft = EVENTS;
  endtask : pulse
  // Four zeros then a mark; counts violation events seen
  task automatic zrun(output int cnt);
    cnt = 0;
    for (int k = 0; k < 8; k++)
    begin
      @(posedge MCLK);
      LINE_BIT_VALID <= k < 5;
      LINE_BIT <= k == 4;
      #1;
      cnt += int'(EVENTS.violation_event_irq);
    end
  endtask : zrun
  // One timeslot byte in both directions
  task automatic sl(input logic [4:0] n, input logic [7:0] d,
    input logic [7:0] r);
    @(posedge MCLK);
    SLOT_VALID <= 1'b1;
    SLOT_NUM <= n;
    SERIAL_DATA_INPUT <= d;
    RX_LINE_DATA <= r;
    @(posedge MCLK);
    SLOT_VALID <= 1'b0;
    #1;
  endtask : sl
  task automatic final_report;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  // Hang guard
  initial
  begin
    repeat (100000) @(posedge MCLK);
    mismatches++;
    final_report;
  end
  //==============================================================
  // Main sequence
  initial
  begin
    logic [8:0] hit;
    logic [8:0] aft;
    logic [7:0] v;
    logic [7:0] c;
    logic [15:0] e;
    int n;
    logic [4:0] cadr [4];
    cadr = '{5'h13, 5'h14, 5'h16, 5'h18};
    repeat (3) @(posedge MCLK);
    RST <= 1'b0;
    // Frame, far end, violation and checksum counters preset to all ones, then counted through the wrap
    for (int i = 0; i < 4; i++)
    begin
      n = 2 + int'(lfsr[2:0]);
      lfsr = step(lfsr);
      if (i == 0)
        host.wr(4'h4, cadr[i], 8'hFF);
      else
        host.wr16(cadr[i], 16'hFFFF);
      for (int k = 0; k < n; k++)
      begin
        pulse(i, hit, aft);
        cmp1(hit[8 - 2 * i], 1'b1);
        cmp1(hit[7 - 2 * i], k == 0);
        cmp1(aft[8 - 2 * i], 1'b0);
      end
      host.rd(4'h4, cadr[i], v);
      cmp8(v, 8'(n - 1));
      host.rd(4'h4, 5'h1F, v);
      cmp8(v, 8'h01 << i);
      host.rd(4'h4, 5'h1F, v);
      cmp8(v, 8'h00);
    end
    $display("test counters done");
    // Violations paused only while out of frame
    host.wr(4'h1, 5'h1A, 8'h04);
    for (int j = 1; j >= 0; j--)
    begin
      @(posedge MCLK);
      LOSS_OF_FRAME <= j == 1;
      pulse(2, hit, aft);
      cmp1(hit[4], j == 0);
    end
    host.wr(4'h1, 5'h1A, 8'h00);
    // Excess zero select and zero substitution mode
    for (int j = 0; j < 3; j++)
    begin
      host.wr(4'h1, 5'h12, j == 2 ? 8'h00 : 8'h20);
      @(posedge MCLK);
      HDB3_MODE <= j != 1;
      zrun(n);
      cmp8(8'(n), j == 0 ? 8'h01 : 8'h00);
    end
    $display("test violations done");
    // Counter clear holds counters at zero, writes too
    host.wr(4'h1, 5'h1A, 8'h10);
    host.wr(4'h4, 5'h18, 8'h55);
    pulse(2, hit, aft);
    host.rd(4'h4, 5'h16, v);
    cmp8(v, 8'h00);
    host.rd(4'h4, 5'h18, v);
    cmp8(v, 8'h00);
    host.wr(4'h1, 5'h1A, 8'h00);
    // Multiframe count, load and clear by error count write
    host.wr(4'h4, 5'h11, 8'h22);
    pulse(4, hit, aft);
    host.rd(4'h4, 5'h11, v);
    cmp8(v, 8'h23);
    host.wr(4'h4, 5'h10, 8'h05);
    host.rd(4'h4, 5'h11, v);
    cmp8(v, 8'h00);
    host.rd(4'h4, 5'h10, v);
    cmp8(v, 8'h05);
    host.rd(4'h4, 5'h02, v);
    cmp8(v, 8'h00);
    $display("test multiframe done");
    // Every injection bit alone; signal loss silences the line
    for (int i = 0; i < 6; i++)
    begin
      host.wr(4'h1, 5'h19, 8'h01 << i);
      sl(5'h03, 8'h5A, 8'hA5);
      cmp8({2'b00, INJECT}, 8'h01 << i);
      cmp1(ENCODER_BYPASS, i == 4);
      cmp8(TX_LINE_DATA, i == 4 ? 8'h00 : 8'h5A);
    end
    host.wr(4'h1, 5'h19, 8'h00);
    $display("test injection done");
    // Random loop and signalling bytes in every slot
    for (int s = 0; s < 32; s++)
    begin
      c = lfsr[7:0] & 8'h33;
      lfsr = step(lfsr);
      if (c[5])
        c[4] = 1'b0;
      if (s == 22)
        c[0] = 1'b1;
      ctl[s] = c;
      host.wr(s < 16 ? 4'hA : 4'hB, 5'(s % 16), c);
    end
    for (int s = 0; s < 32; s++)
    begin
      e = lfsr;
      lfsr = step(lfsr);
      sl(5'(s), e[15:8], e[7:0]);
      cmp8(SLOT_CTRL, ctl[s]);
      cmp8(TX_LINE_DATA, 8'(path_exp(ctl[s], e[15:8], e[7:0]) >> 8));
      cmp8(SERIAL_DATA_OUTPUT, 8'(path_exp(ctl[s], e[15:8], e[7:0])));
      cmp1(SIG_FROM_HOST, ctl[s][1]);
      cmp1(ROBBED_BIT_ENABLE, 1'b0);
      cmp1(SLOT_OUT_VALID, 1'b1);
    end
    // T1: clear channel and the slots past the last channel
    @(posedge MCLK);
    E1_MODE <= 1'b0;
    for (int s = 22; s < 26; s++)
    begin
      sl(5'(s), 8'h3C, 8'hC3);
      cmp1(ROBBED_BIT_ENABLE, s > 23 || !ctl[s][0]);
      cmp8(SLOT_CTRL, s > 23 ? 8'h00 : ctl[s]);
    end
    // Sequence sent, looped back clean, last byte inverted
    host.wr(4'hA, 5'h00, 8'h08);
    for (int k = 0; k < 8; k++)
    begin
      if (k == 4)
        host.wr(4'hA, 5'h00, 8'h04);
      sl(5'h00, 8'h00, ctl[k ^ 4] ^ {8{k == 7}});
      ctl[k] = TX_LINE_DATA;
    end
    host.rd(4'h4, 5'h10, v);
    cmp8(v, 8'h06);
    $display("test slots done");
    final_report;
  end
endmodule : tb_top
